/* msf_map.svh */
// Register offsets, field positions, reset values and coding constants of the filter control bank
`ifndef MSF_MAP_SVH
`define MSF_MAP_SVH

// Register offsets on the primary serial interface
`define MSF_ADDR_TRIG      8'h15
`define MSF_ADDR_GYRO      8'h16
`define MSF_ADDR_ACCEL     8'h17
`define MSF_ADDR_STAMP     8'h18
`define MSF_ADDR_FUNC      8'h19
`define MSF_ADDR_TS0       8'h40
`define MSF_ADDR_TS1       8'h41
`define MSF_ADDR_TS2       8'h42

// Burst wrap ring: event sources, status, then function source
`define MSF_WRAP_FIRST     8'h1B
`define MSF_WRAP_LAST      8'h1E
`define MSF_FUNC_SRC       8'h53

// Writable bit masks; reserved positions are held at zero
`define MSF_MASK_TRIG      8'hFB
`define MSF_MASK_GYRO      8'hF4
`define MSF_MASK_ACCEL     8'hFD
`define MSF_MASK_STAMP     8'hF4
`define MSF_MASK_FUNC      8'hBF

// Reset values
`define MSF_RST_TRIG       8'h00
`define MSF_RST_GYRO       8'h00
`define MSF_RST_ACCEL      8'h00
`define MSF_RST_STAMP      8'hE0
`define MSF_RST_FUNC       8'h00

// Trigger and performance control register fields
`define MSF_B_EDGE_TRIG    7
`define MSF_B_LEVEL_TRIG   6
`define MSF_B_LEVEL_LATCH  5
`define MSF_B_XL_HP_DIS    4
`define MSF_B_OFS_WEIGHT   3
`define MSF_B_GYRO_LOWPASS_TYPE_HI     1
`define MSF_B_GYRO_LOWPASS_TYPE_LO     0

// Gyro mode and high-pass register fields
`define MSF_B_G_HP_DIS     7
`define MSF_B_G_HPF_EN     6
`define MSF_B_G_HPM_HI     5
`define MSF_B_G_HPM_LO     4
`define MSF_B_ROUND_STAT   2

// Accel filter path register fields
`define MSF_B_SECOND_LOWPASS_EN      7
`define MSF_B_CUT_HI       6
`define MSF_B_CUT_LO       5
`define MSF_B_HP_REF       4
`define MSF_B_COMPOSITE    3
`define MSF_B_SLOPE_SEL    2
`define MSF_B_ORIENT_LP    0

// Stamp axis and soft-iron register fields
`define MSF_B_STAMP_X      7
`define MSF_B_STAMP_Z      5
`define MSF_B_STAMP_SENSOR 4
`define MSF_B_SOFT_IRON    2

// Embedded function enable register fields
`define MSF_B_WRIST        7
`define MSF_B_TIMER        5
`define MSF_B_STEP         4
`define MSF_B_TILT         3
`define MSF_B_MASTER       2
`define MSF_B_STEP_CLR     1
`define MSF_B_SIG_MOTION   0

// Offset weight exponents (LSB = 2^-n g) and bandwidth divisors of ODR
`define MSF_OFS_EXP_FINE   4'hA
`define MSF_OFS_EXP_COARSE 4'h6
`define MSF_DIV_2          9'h002
`define MSF_DIV_4          9'h004
`define MSF_DIV_9          9'h009
`define MSF_DIV_50         9'h032
`define MSF_DIV_100        9'h064
`define MSF_DIV_400        9'h190

`endif

/* msf_pkg.sv */
// Types shared by the filter control bank
package msf_pkg;

	// Data-enable trigger behaviour decoded from the three enable bits
	typedef enum logic [2:0] {
		MSF_TRIG_NONE,
		MSF_TRIG_EDGE,
		MSF_TRIG_LEVEL,
		MSF_TRIG_LATCHED,
		MSF_TRIG_FIFO
	} msf_trig_e;

	// Axis and sign an orientation algorithm works on
	typedef enum logic [2:0] {
		MSF_AXIS_POS_X,
		MSF_AXIS_NEG_X,
		MSF_AXIS_POS_Y,
		MSF_AXIS_NEG_Y,
		MSF_AXIS_POS_Z,
		MSF_AXIS_NEG_Z
	} msf_axis_e;

endpackage

/* msf_ctrl.sv */
// Filter and function control register bank with decoded control outputs
// Behaviour
// - Trigger bits 100/010/011/110 select edge, level, latched, FIFO-enable modes.
// - Accel high-performance disable resets 0; 1 selects low-power/normal rates.
// - Offset weight bit: 0 gives 2^-10 g per LSB, 1 gives 2^-6 g.
// - Gyro low-pass type picks bandwidth; valid only while auxiliary SPI is off.
// - Gyro high-performance disable resets 0; 1 selects low-power/normal rates.
// - Gyro high-pass resets off; runs only when enabled and in high-performance.
// - Gyro high-pass cutoff resets 00: 16 mHz, 65 mHz, 260 mHz, 1.04 Hz.
// - Status rounding makes bursts wrap 1Bh to 1Eh then 53h; resets 0.
// - Composite input select resets 0 for ODR/2; 1 feeds ODR/4.
// - Low-pass path: ODR/2 or ODR/4, or with SECOND_LOWPASS ODR/50,100,9,400.
// - High-pass path: code 00 slope at ODR/4, else ODR/100,9,400.
// - Per-axis stamp bits reset 1; set bits receive the data-enable pin value.
// - Stamp sensor select resets 0 for gyro axes; 1 stamps accel axes.
// - Soft-iron enable resets 0; acts only with hard-iron and master enable.
// - Timestamp enable starts the counter readable at 40h to 42h; resets 0.
// - Master enable resets 0 and gates the accel filters and every embedded function except the timestamp and the step count clear.
// - Step, tilt, wrist tilt and motion enables act only under master enable.
// - Wrist tilt detection works on the positive X axis.
// - Writing 1 to step count clear clears the step count; bit resets 0.
// - First low-pass bandwidth select from another register picks ODR/2 or ODR/4.
// - Hard-iron enable from master configuration turns hard-iron correction on while master enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module msf_ctrl (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic             reg_wr_i,
	input  wire logic [7:0]       reg_wdata_i,
	input  wire logic             reg_rd_i,
	output var  logic [7:0]       reg_rdata_o,
	input  wire logic [7:0]       burst_addr_i,
	output var  logic [7:0]       burst_next_o,
	input  wire logic             data_enable_pin_i,
	input  wire logic             aux_spi_enable_i,
	input  wire logic             accel_first_lowpass_bw_i,
	input  wire logic             hard_iron_enable_i,
	input  wire logic             timestamp_tick_i,
	output var  msf_pkg::msf_trig_e trig_mode_o,
	output var  logic             accel_highperf_o,
	output var  logic             gyro_highperf_o,
	output var  logic [3:0]       offset_lsb_exp_o,
	output var  logic [1:0]       gyro_lowpass_type_o,
	output var  logic             gyro_lowpass_valid_o,
	output var  logic             gyro_highpass_active_o,
	output var  logic [1:0]       gyro_highpass_cutoff_o,
	output var  logic             status_wrap_o,
	output var  logic [8:0]       accel_bw_div_o,
	output var  logic             accel_slope_active_o,
	output var  logic             accel_highpass_active_o,
	output var  logic             accel_second_lowpass_o,
	output var  logic             accel_highpass_reference_o,
	output var  logic [8:0]       composite_in_div_o,
	output var  logic             orientation_lowpass_select_o,
	output var  logic [2:0]       stamp_gyro_axes_o,
	output var  logic [2:0]       stamp_accel_axes_o,
	output var  logic             stamp_bit_o,
	output var  logic             hard_iron_active_o,
	output var  logic             soft_iron_active_o,
	output var  logic [23:0]      timestamp_o,
	output var  logic             step_active_o,
	output var  logic             tilt_active_o,
	output var  logic             wrist_tilt_active_o,
	output var  logic             sig_motion_active_o,
	output var  logic             hub_iron_enable_o,
	output var  msf_pkg::msf_axis_e wrist_axis_o,
	output var  logic             step_count_clear_o
);

	logic [7:0] trig_reg;
	logic [7:0] gyro_reg;
	logic [7:0] accel_reg;
	logic [7:0] stamp_reg;
	logic [7:0] func_reg;
	logic       master_en;
	logic       trig_live;

	// Keeps reserved positions at zero whatever the host sends
	function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
		return d & m;
	endfunction

	function automatic logic wr_hit(input logic [7:0] a);
		return reg_wr_i && (reg_addr_i == a);
	endfunction

	// Undefined codes fall to NONE so no stamping or gating happens
	function automatic msf_pkg::msf_trig_e trig_decode(input logic [2:0] c);
		case (c)
			3'h4:    return msf_pkg::MSF_TRIG_EDGE;
			3'h2:    return msf_pkg::MSF_TRIG_LEVEL;
			3'h3:    return msf_pkg::MSF_TRIG_LATCHED;
			3'h6:    return msf_pkg::MSF_TRIG_FIFO;
			default: return msf_pkg::MSF_TRIG_NONE;
		endcase
	endfunction

	// Bandwidth divisor of ODR for the accel path
	function automatic logic [8:0] accel_div(input logic slope, input logic second_lowpass,
		input logic bw_sel, input logic [1:0] cut);
		if (!slope && !second_lowpass) begin
			return bw_sel ? `MSF_DIV_4 : `MSF_DIV_2;
		end
		case (cut)
			2'h0:    return slope ? `MSF_DIV_4 : `MSF_DIV_50;
			2'h1:    return `MSF_DIV_100;
			2'h2:    return `MSF_DIV_9;
			default: return `MSF_DIV_400;
		endcase
	endfunction

	// Register writes, one process per register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_reg <= `MSF_RST_TRIG;
		end else if (wr_hit(`MSF_ADDR_TRIG)) begin
			trig_reg <= masked(reg_wdata_i, `MSF_MASK_TRIG);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gyro_reg <= `MSF_RST_GYRO;
		end else if (wr_hit(`MSF_ADDR_GYRO)) begin
			gyro_reg <= masked(reg_wdata_i, `MSF_MASK_GYRO);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			accel_reg <= `MSF_RST_ACCEL;
		end else if (wr_hit(`MSF_ADDR_ACCEL)) begin
			accel_reg <= masked(reg_wdata_i, `MSF_MASK_ACCEL);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stamp_reg <= `MSF_RST_STAMP;
		end else if (wr_hit(`MSF_ADDR_STAMP)) begin
			stamp_reg <= masked(reg_wdata_i, `MSF_MASK_STAMP);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			func_reg <= `MSF_RST_FUNC;
		end else if (wr_hit(`MSF_ADDR_FUNC)) begin
			func_reg <= masked(reg_wdata_i, `MSF_MASK_FUNC);
		end
	end

	assign master_en = func_reg[`MSF_B_MASTER];
	assign trig_live = trig_decode(trig_reg[7:5]) != msf_pkg::MSF_TRIG_NONE;

	// Clear pulse follows each write carrying the clear bit set
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			step_count_clear_o <= 1'b0;
		end else begin
			step_count_clear_o <= wr_hit(`MSF_ADDR_FUNC) && reg_wdata_i[`MSF_B_STEP_CLR];
		end
	end

	// Timestamp runs on the external tick; holds its value while disabled
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timestamp_o <= 24'h000000;
		end else if (func_reg[`MSF_B_TIMER] && timestamp_tick_i) begin
			timestamp_o <= timestamp_o + 24'h000001;
		end
	end

	// Read port: answer registered one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`MSF_ADDR_TRIG:  reg_rdata_o <= trig_reg;
				`MSF_ADDR_GYRO:  reg_rdata_o <= gyro_reg;
				`MSF_ADDR_ACCEL: reg_rdata_o <= accel_reg;
				`MSF_ADDR_STAMP: reg_rdata_o <= stamp_reg;
				`MSF_ADDR_FUNC:  reg_rdata_o <= func_reg;
				`MSF_ADDR_TS0:   reg_rdata_o <= timestamp_o[7:0];
				`MSF_ADDR_TS1:   reg_rdata_o <= timestamp_o[15:8];
				`MSF_ADDR_TS2:   reg_rdata_o <= timestamp_o[23:16];
				default:         reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Burst address stepping; wrap ring only while status rounding is on
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			burst_next_o <= 8'h00;
		end else if (gyro_reg[`MSF_B_ROUND_STAT] && burst_addr_i == `MSF_WRAP_LAST) begin
			burst_next_o <= `MSF_FUNC_SRC;
		end else if (gyro_reg[`MSF_B_ROUND_STAT] && burst_addr_i == `MSF_FUNC_SRC) begin
			burst_next_o <= `MSF_WRAP_FIRST;
		end else begin
			burst_next_o <= burst_addr_i + 8'h01;
		end
	end

	// Trigger, performance and gyro filter decode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_mode_o            <= msf_pkg::MSF_TRIG_NONE;
			accel_highperf_o       <= 1'b1;
			gyro_highperf_o        <= 1'b1;
			offset_lsb_exp_o       <= `MSF_OFS_EXP_FINE;
			gyro_lowpass_type_o    <= 2'h0;
			gyro_lowpass_valid_o   <= 1'b0;
			gyro_highpass_active_o <= 1'b0;
			gyro_highpass_cutoff_o <= 2'h0;
			status_wrap_o          <= 1'b0;
		end else begin
			trig_mode_o            <= trig_decode(trig_reg[7:5]);
			accel_highperf_o       <= !trig_reg[`MSF_B_XL_HP_DIS];
			gyro_highperf_o        <= !gyro_reg[`MSF_B_G_HP_DIS];
			offset_lsb_exp_o       <= trig_reg[`MSF_B_OFS_WEIGHT] ?
				`MSF_OFS_EXP_COARSE : `MSF_OFS_EXP_FINE;
			gyro_lowpass_type_o    <= trig_reg[`MSF_B_GYRO_LOWPASS_TYPE_HI:`MSF_B_GYRO_LOWPASS_TYPE_LO];
			gyro_lowpass_valid_o   <= !aux_spi_enable_i;
			gyro_highpass_active_o <= gyro_reg[`MSF_B_G_HPF_EN] && !gyro_reg[`MSF_B_G_HP_DIS];
			gyro_highpass_cutoff_o <= gyro_reg[`MSF_B_G_HPM_HI:`MSF_B_G_HPM_LO];
			status_wrap_o          <= gyro_reg[`MSF_B_ROUND_STAT];
		end
	end

	// Accel filter path; the filters themselves idle without the master enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			accel_bw_div_o               <= `MSF_DIV_2;
			accel_slope_active_o         <= 1'b0;
			accel_highpass_active_o      <= 1'b0;
			accel_second_lowpass_o       <= 1'b0;
			accel_highpass_reference_o   <= 1'b0;
			composite_in_div_o           <= `MSF_DIV_2;
			orientation_lowpass_select_o <= 1'b0;
		end else begin
			accel_bw_div_o <= accel_div(accel_reg[`MSF_B_SLOPE_SEL], accel_reg[`MSF_B_SECOND_LOWPASS_EN],
				accel_first_lowpass_bw_i, accel_reg[`MSF_B_CUT_HI:`MSF_B_CUT_LO]);
			accel_slope_active_o <= master_en && accel_reg[`MSF_B_SLOPE_SEL] &&
				accel_reg[`MSF_B_CUT_HI:`MSF_B_CUT_LO] == 2'h0;
			accel_highpass_active_o <= master_en && accel_reg[`MSF_B_SLOPE_SEL] &&
				accel_reg[`MSF_B_CUT_HI:`MSF_B_CUT_LO] != 2'h0;
			accel_second_lowpass_o <= master_en && !accel_reg[`MSF_B_SLOPE_SEL] &&
				accel_reg[`MSF_B_SECOND_LOWPASS_EN];
			// Host drops the first sample after this turns on; nothing is held back here
			accel_highpass_reference_o   <= accel_reg[`MSF_B_HP_REF];
			composite_in_div_o           <= accel_reg[`MSF_B_COMPOSITE] ?
				`MSF_DIV_4 : `MSF_DIV_2;
			orientation_lowpass_select_o <= accel_reg[`MSF_B_ORIENT_LP];
		end
	end

	// Stamping: pin value sampled each cycle, axes gated by a defined trigger mode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stamp_gyro_axes_o  <= 3'h0;
			stamp_accel_axes_o <= 3'h0;
			stamp_bit_o        <= 1'b0;
		end else begin
			stamp_gyro_axes_o  <= (trig_live && !stamp_reg[`MSF_B_STAMP_SENSOR]) ?
				stamp_reg[`MSF_B_STAMP_X:`MSF_B_STAMP_Z] : 3'h0;
			stamp_accel_axes_o <= (trig_live && stamp_reg[`MSF_B_STAMP_SENSOR]) ?
				stamp_reg[`MSF_B_STAMP_X:`MSF_B_STAMP_Z] : 3'h0;
			stamp_bit_o        <= data_enable_pin_i;
		end
	end

	// Embedded functions, all behind the master enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hard_iron_active_o  <= 1'b0;
			soft_iron_active_o  <= 1'b0;
			step_active_o       <= 1'b0;
			tilt_active_o       <= 1'b0;
			wrist_tilt_active_o <= 1'b0;
			sig_motion_active_o <= 1'b0;
			hub_iron_enable_o   <= 1'b0;
			wrist_axis_o        <= msf_pkg::MSF_AXIS_POS_X;
		end else begin
			hard_iron_active_o  <= master_en && hard_iron_enable_i;
			soft_iron_active_o  <= master_en && hard_iron_enable_i &&
				stamp_reg[`MSF_B_SOFT_IRON];
			step_active_o       <= master_en && func_reg[`MSF_B_STEP];
			tilt_active_o       <= master_en && func_reg[`MSF_B_TILT];
			wrist_tilt_active_o <= master_en && func_reg[`MSF_B_WRIST];
			sig_motion_active_o <= master_en && func_reg[`MSF_B_SIG_MOTION];
			hub_iron_enable_o   <= master_en;
			wrist_axis_o        <= msf_pkg::MSF_AXIS_POS_X;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_func_write_master_off;
		wr_hit(`MSF_ADDR_FUNC) && !reg_wdata_i[`MSF_B_MASTER];
	endsequence

	sequence s_func_write_clear;
		wr_hit(`MSF_ADDR_FUNC) && reg_wdata_i[`MSF_B_STEP_CLR];
	endsequence

	a_trig_undefined_idle: assert property (
		wr_hit(`MSF_ADDR_TRIG) && reg_wdata_i[7:5] == 3'h7 |-> ##2
		trig_mode_o == msf_pkg::MSF_TRIG_NONE && stamp_gyro_axes_o == 3'h0)
		else $error("undefined trigger code did not idle");
	a_trig_edge_code: assert property (
		wr_hit(`MSF_ADDR_TRIG) && reg_wdata_i[7:5] == 3'h4 |-> ##2
		trig_mode_o == msf_pkg::MSF_TRIG_EDGE)
		else $error("code 100 not edge mode");
	a_accel_perf_mode: assert property (
		wr_hit(`MSF_ADDR_TRIG) |-> ##2 accel_highperf_o == !$past(reg_wdata_i[4], 2))
		else $error("accel performance mode wrong");
	a_offset_weight: assert property (
		wr_hit(`MSF_ADDR_TRIG) && reg_wdata_i[3] |-> ##2 offset_lsb_exp_o == 4'h6)
		else $error("offset weight not coarse");
	a_gyro_hpf_gate: assert property (
		gyro_highpass_active_o |-> $past(gyro_reg[`MSF_B_G_HPF_EN])
		&& !$past(gyro_reg[`MSF_B_G_HP_DIS]))
		else $error("gyro high-pass active outside high-performance");
	a_wrap_ring: assert property (
		status_wrap_o && gyro_reg[`MSF_B_ROUND_STAT] && burst_addr_i == 8'h1E
		|=> burst_next_o == 8'h53)
		else $error("burst did not wrap to function source");
	a_composite_div: assert property (
		wr_hit(`MSF_ADDR_ACCEL) |-> ##2
		composite_in_div_o == ($past(reg_wdata_i[3], 2) ? 9'h004 : 9'h002))
		else $error("composite input divisor wrong");
	a_second_lowpass_cutoff: assert property (
		wr_hit(`MSF_ADDR_ACCEL) && reg_wdata_i[7:5] == 3'h4 && !reg_wdata_i[2]
		|-> ##2 accel_bw_div_o == 9'h032)
		else $error("second low-pass code 00 not ODR/50");
	a_slope_cutoff: assert property (
		wr_hit(`MSF_ADDR_ACCEL) && reg_wdata_i[6:5] == 2'h0 && reg_wdata_i[2]
		|-> ##2 accel_bw_div_o == 9'h004)
		else $error("slope filter not ODR/4");
	a_master_gates: assert property (
		s_func_write_master_off |-> ##2 !step_active_o && !tilt_active_o
		&& !wrist_tilt_active_o && !sig_motion_active_o && !soft_iron_active_o)
		else $error("function active without master enable");
	a_clear_pulse: assert property (
		s_func_write_clear |=> step_count_clear_o ##1 !step_count_clear_o
		|| $past(reg_wr_i))
		else $error("step clear pulse missing");
	a_timestamp_count: assert property (
		func_reg[`MSF_B_TIMER] && timestamp_tick_i |=>
		timestamp_o == $past(timestamp_o) + 24'h000001)
		else $error("timestamp did not advance");

endmodule // msf_ctrl

`default_nettype wire

/* msf_host.sv */
// Host processor model driving the register port of the filter control bank
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module msf_host (
	input  wire logic       clk_i,
	output var  logic [7:0] reg_addr_o,
	output var  logic       reg_wr_o,
	output var  logic [7:0] reg_wdata_o,
	output var  logic       reg_rd_o,
	input  wire logic [7:0] reg_rdata_i
);
	logic discard_next;

	// Bus idle from time zero
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
		discard_next = 1'b0;
	end

	// Reserved positions go out as zero while the write strobe is high
	function automatic logic [7:0] keep(input logic [7:0] a, input logic [7:0] d);
		case (a)
			`MSF_ADDR_TRIG: keep = d & `MSF_MASK_TRIG;
			`MSF_ADDR_GYRO: keep = d & `MSF_MASK_GYRO;
			`MSF_ADDR_ACCEL: keep = d & `MSF_MASK_ACCEL;
			`MSF_ADDR_STAMP: keep = d & `MSF_MASK_STAMP;
			`MSF_ADDR_FUNC: keep = d & `MSF_MASK_FUNC;
			default: keep = d;
		endcase
	endfunction

	// One write; lines show the inverse once the strobe is gone
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= keep(a, d);
		reg_wr_o <= 1'b1;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~keep(a, d);
		reg_addr_o <= ~a;
		// First sample after reference mode must be thrown away
		if (a == `MSF_ADDR_ACCEL) discard_next = d[`MSF_B_HP_REF];
	endtask

	// One read; data is registered, so it is taken after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask
endmodule // msf_host

`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the filter control bank
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module tb_top;
	logic clk_i, rst_i, reg_wr_i, reg_rd_i, pin, aux, bw, hard, tick;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, burst_addr_i, burst_next_o, rv;
	msf_pkg::msf_trig_e trig_mode_o;
	msf_pkg::msf_axis_e wrist_axis_o;
	logic accel_hp, gyro_hp, lp_valid, g_hp_act, wrap, slope_act, hp_act, lp2, hp_ref;
	logic orient, stamp_bit, hard_act, soft_act, step_act, tilt_act, wrist_act, sig_act;
	logic hub, step_clr;
	logic [3:0] ofs_exp;
	logic [1:0] lp_type, hp_cut;
	logic [8:0] bw_div, comp_div;
	logic [2:0] st_g, st_a;
	logic [23:0] ts;
	int n_fail = 0;
	int num_checks = 0;

	msf_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.burst_addr_i(burst_addr_i), .burst_next_o(burst_next_o), .data_enable_pin_i(pin),
		.aux_spi_enable_i(aux), .accel_first_lowpass_bw_i(bw), .hard_iron_enable_i(hard),
		.timestamp_tick_i(tick), .trig_mode_o(trig_mode_o), .accel_highperf_o(accel_hp),
		.gyro_highperf_o(gyro_hp), .offset_lsb_exp_o(ofs_exp), .gyro_lowpass_type_o(lp_type),
		.gyro_lowpass_valid_o(lp_valid), .gyro_highpass_active_o(g_hp_act),
		.gyro_highpass_cutoff_o(hp_cut), .status_wrap_o(wrap), .accel_bw_div_o(bw_div),
		.accel_slope_active_o(slope_act), .accel_highpass_active_o(hp_act),
		.accel_second_lowpass_o(lp2), .accel_highpass_reference_o(hp_ref),
		.composite_in_div_o(comp_div), .orientation_lowpass_select_o(orient),
		.stamp_gyro_axes_o(st_g), .stamp_accel_axes_o(st_a), .stamp_bit_o(stamp_bit),
		.hard_iron_active_o(hard_act), .soft_iron_active_o(soft_act), .timestamp_o(ts),
		.step_active_o(step_act), .tilt_active_o(tilt_act), .wrist_tilt_active_o(wrist_act),
		.sig_motion_active_o(sig_act), .hub_iron_enable_o(hub), .wrist_axis_o(wrist_axis_o),
		.step_count_clear_o(step_clr));

	msf_host host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Wide enough for the soft-iron bit packed above the 24-bit timestamp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Decoded outputs lag the taking edge by one more edge
	task automatic settle;
		repeat (2) @(negedge clk_i);
	endtask

	task automatic end_of_test;
		$display("Checks %0d, failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	function automatic msf_pkg::msf_trig_e texp(input logic [2:0] c);
		case (c)
			3'h4: texp = msf_pkg::MSF_TRIG_EDGE;
			3'h2: texp = msf_pkg::MSF_TRIG_LEVEL;
			3'h3: texp = msf_pkg::MSF_TRIG_LATCHED;
			3'h6: texp = msf_pkg::MSF_TRIG_FIFO;
			default: texp = msf_pkg::MSF_TRIG_NONE;
		endcase
	endfunction

	// Divisor expected from slope/SECOND_LOWPASS/cutoff/first-filter select
	function automatic logic [8:0] adiv(input logic s, input logic l, input logic [1:0] c,
		input logic b);
		logic [8:0] tab [4];
		tab = '{9'h032, 9'h064, 9'h009, 9'h190};
		if (s) adiv = (c == 2'h0) ? 9'h004 : tab[c];
		else if (l) adiv = tab[c];
		else adiv = b ? 9'h004 : 9'h002;
	endfunction

	task automatic t_reset;
		logic [7:0] rst_val [5];
		rst_val = '{8'h00, 8'h00, 8'h00, 8'hE0, 8'h00};
		for (int i = 0; i < 5; i++) begin
			host.rd(8'h15 + 8'(i), rv);
			chk(rv, rst_val[i]);
		end
		host.rd(8'h20, rv);
		chk(rv, 8'h00);
		chk({accel_hp, gyro_hp, wrap, ofs_exp}, 7'h6A);
		chk(comp_div, 9'h002);
		chk(wrist_axis_o, msf_pkg::MSF_AXIS_POS_X);
	endtask

	task automatic t_trig;
		for (int c = 0; c < 8; c++) begin
			host.wr(`MSF_ADDR_TRIG, {3'(c), 5'h00});
			settle();
			chk(trig_mode_o, texp(3'(c)));
			chk(st_g, (texp(3'(c)) == msf_pkg::MSF_TRIG_NONE) ? 3'h0 : 3'h7);
		end
		host.wr(`MSF_ADDR_TRIG, 8'h80);
		host.wr(`MSF_ADDR_STAMP, 8'hB0);
		@(posedge clk_i);
		pin <= 1'b1;
		settle();
		chk({st_a, st_g, stamp_bit}, 7'h51);
		@(posedge clk_i);
		pin <= 1'b0;
		settle();
		chk(stamp_bit, 1'b0);
	endtask

	task automatic t_perf;
		host.wr(`MSF_ADDR_TRIG, 8'h1B);
		settle();
		chk({accel_hp, ofs_exp, lp_type, lp_valid}, 8'h37);
		@(posedge clk_i);
		aux <= 1'b1;
		settle();
		chk(lp_valid, 1'b0);
		host.wr(`MSF_ADDR_GYRO, 8'h40);
		settle();
		chk({g_hp_act, hp_cut}, 3'h4);
		host.wr(`MSF_ADDR_GYRO, 8'hC0);
		settle();
		chk({gyro_hp, g_hp_act}, 2'h0);
		host.wr(`MSF_ADDR_GYRO, 8'h74);
		settle();
		chk({g_hp_act, hp_cut, wrap}, 4'hF);
	endtask

	task automatic t_burst;
		logic [7:0] bi [5];
		logic [7:0] bo [5];
		bi = '{8'h1B, 8'h1D, 8'h1E, 8'h53, 8'h30};
		bo = '{8'h1C, 8'h1E, 8'h53, 8'h1B, 8'h31};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			burst_addr_i <= bi[i];
			settle();
			chk(burst_next_o, bo[i]);
		end
		host.wr(`MSF_ADDR_GYRO, 8'h00);
		@(posedge clk_i);
		burst_addr_i <= 8'h1E;
		settle();
		chk(burst_next_o, 8'h1F);
	endtask

	task automatic t_accel;
		logic [3:0] v;
		host.wr(`MSF_ADDR_FUNC, 8'h04);
		for (int i = 0; i < 16; i++) begin
			v = 4'(i);
			@(posedge clk_i);
			bw <= v[0];
			host.wr(`MSF_ADDR_ACCEL, {v[2], v[1:0], 1'b0, v[1], v[3], 2'h0});
			settle();
			chk(bw_div, adiv(v[3], v[2], v[1:0], v[0]));
			chk(comp_div, v[1] ? 9'h004 : 9'h002);
			chk({slope_act, hp_act}, {v[3] && v[1:0] == 2'h0, v[3] && v[1:0] != 2'h0});
			chk(lp2, v[2] && !v[3]);
		end
		host.wr(`MSF_ADDR_FUNC, 8'h00);
		settle();
		chk(hp_act, 1'b0);
		// Reference mode on: the host marks its next sample as one to drop
		host.wr(`MSF_ADDR_ACCEL, 8'h11);
		settle();
		chk({hp_ref, orient, host.discard_next}, 3'h7);
	endtask

	task automatic t_func;
		host.wr(`MSF_ADDR_FUNC, 8'hB9);
		@(posedge clk_i);
		hard <= 1'b1;
		host.wr(`MSF_ADDR_STAMP, 8'h04);
		settle();
		chk({step_act, tilt_act, wrist_act, sig_act, hub, soft_act, hard_act}, 7'h00);
		host.wr(`MSF_ADDR_FUNC, 8'hBD);
		settle();
		chk({step_act, tilt_act, wrist_act, sig_act, hub, soft_act, hard_act}, 7'h7F);
		@(posedge clk_i);
		hard <= 1'b0;
		tick <= 1'b1;
		repeat (5) @(posedge clk_i);
		tick <= 1'b0;
		settle();
		chk({soft_act, ts}, 25'h0000005);
		host.rd(`MSF_ADDR_TS0, rv);
		chk(rv, 8'h05);
		host.wr(`MSF_ADDR_FUNC, 8'h9D);
		settle();
		@(posedge clk_i);
		tick <= 1'b1;
		repeat (3) @(posedge clk_i);
		tick <= 1'b0;
		settle();
		chk(ts, 24'h000005);
		host.wr(`MSF_ADDR_FUNC, 8'h06);
		@(negedge clk_i);
		chk(step_clr, 1'b1);
		@(negedge clk_i);
		chk(step_clr, 1'b0);
	endtask

	// Watchdog: the whole run needs well under 2000 cycles
	initial begin
		#(40 * 4000);
		n_fail++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		end_of_test();
	end

	// Reset for 6 cycles, then the scenarios
	initial begin
		rst_i = 1'b1;
		{pin, aux, bw, hard, tick} = 5'h00;
		burst_addr_i = 8'h00;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_trig();
		t_perf();
		t_burst();
		t_accel();
		t_func();
		end_of_test();
	end
endmodule // tb_top

`default_nettype wire
